// ### verilog/crc_engine.sv
// checksum engine with byte port, result port, bit mirror and memory scan
// assumes an apb master on pclk and a memory answering in the same cycle that req stands
//
// What this block does
// - checksum uses polynomial 0x1021 for both byte port and memory scan bytes.
// - only two seeds exist, 0x0000 and 0xFFFF.
// - init select bit 0 gives zero seed, 1 gives all-ones seed.
// - writing 1 to init strobe loads the seed; software seeds first.
// - each input byte folds into the result at once, in write order.
// - auto mode reads memory and checksums whole 256-byte blocks.
// - any control write while auto enabled and block count nonzero starts the scan.
// - cpu stalls during the scan until the last block is folded.
// - result is one 16-bit register.
// - result pointer picks the byte of each result access, then advances.
// - result changes only by seeding, overwriting or folding bytes.
// - bit reverse port reads back its byte mirrored.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module crc_engine
  import crc_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic cpu_stall, // holds cpu during scan
  output logic mem_req, // memory read strobe
  output logic [15:0] mem_addr, // memory byte address
  input wire logic [7:0] mem_rdata // memory data, valid while req stands
);
  crc_state_type s_reg, s_next; // result lives in s_reg.crc, one 16-bit register
  logic [15:0] fold_bus, fold_mem;
  logic [7:0] flipped;
  logic access, wr, rd;
  logic unmapped_reg;
  logic unmapped_next;

  // byte port and memory fold each use their own instance of the same step logic
  crc_byte_step u_fold_bus (.crc_in(s_reg.crc), .data(pwdata[7:0]), .crc_out(fold_bus));
  crc_byte_step u_fold_mem (.crc_in(s_reg.crc), .data(mem_rdata), .crc_out(fold_mem));
  bit_mirror u_mirror (.din(s_reg.flip), .dout(flipped));

  // an apb access is taken in the first access cycle, pready follows one cycle later
  assign access = psel && penable && !s_reg.pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.pready = access;
    s_next.mem_req = 1'b0;
    unmapped_next = 1'b0;
    if (access)
      unmapped_next = !(paddr inside {OFF_CONTROL, OFF_INPUT, OFF_RESULT, OFF_AUTO,
        OFF_COUNT, OFF_FLIP});
    if (rd)
    begin
      unique case (paddr)
        OFF_CONTROL: s_next.prdata = {27'h000_0000, s_reg.st != IDLE, 1'b0, s_reg.sel,
          1'b0, s_reg.pnt};
        OFF_RESULT:
        begin
          s_next.prdata = {24'h00_0000, s_reg.pnt ? s_reg.crc[15:8] : s_reg.crc[7:0]};
          s_next.pnt = ~s_reg.pnt;
        end
        OFF_AUTO: s_next.prdata = {24'h00_0000, s_reg.auto_cfg};
        OFF_COUNT: s_next.prdata = {24'h00_0000, s_reg.count};
        OFF_FLIP: s_next.prdata = {24'h00_0000, flipped};
        default: s_next.prdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      unique case (paddr)
        OFF_CONTROL:
        begin
          s_next.sel = pwdata[CTL_SEL_BIT];
          s_next.pnt = pwdata[CTL_PNT_BIT];
          if (pwdata[CTL_INIT_BIT])
            s_next.crc = pwdata[CTL_SEL_BIT] ? SEED_ONE : SEED_ZERO;
          if (s_reg.auto_cfg[AUTO_EN_BIT] && s_reg.count != RESET_BYTE)
          begin
            s_next.st = REQ;
            s_next.offset = RESET_BYTE;
            s_next.stall = 1'b1;
          end
        end
        OFF_INPUT: s_next.crc = fold_bus;
        OFF_RESULT:
        begin
          if (s_reg.pnt)
            s_next.crc[15:8] = pwdata[7:0];
          else
            s_next.crc[7:0] = pwdata[7:0];
          s_next.pnt = ~s_reg.pnt;
        end
        OFF_AUTO: s_next.auto_cfg = pwdata[7:0];
        OFF_COUNT: s_next.count = pwdata[7:0];
        OFF_FLIP: s_next.flip = pwdata[7:0];
        default: ;
      endcase
    end
    // scan engine: one byte per two cycles, blocks of 256 bytes
    unique case (s_reg.st)
      IDLE: ;
      REQ:
      begin
        s_next.mem_req = 1'b1;
        s_next.mem_addr = {s_reg.auto_cfg[6:0], 1'b0, 8'h00} + {8'h00, s_reg.offset};
        s_next.st = WAITD;
      end
      WAITD:
      begin
        s_next.crc = fold_mem;
        s_next.offset = s_reg.offset + 8'h01;
        s_next.st = REQ;
        if (s_reg.offset == BLOCK_LAST)
        begin
          s_next.count = s_reg.count - 8'h01;
          if (s_reg.count == 8'h01)
          begin
            s_next.st = IDLE;
            s_next.stall = 1'b0;
          end
          else
            s_next.auto_cfg = s_reg.auto_cfg + 8'h01;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      unmapped_reg <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
      unmapped_reg <= unmapped_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = unmapped_reg;
  assign cpu_stall = s_reg.stall;
  assign mem_req = s_reg.mem_req;
  assign mem_addr = s_reg.mem_addr;

  // assertions
  sequence s_seed_write;
    wr && paddr == OFF_CONTROL && pwdata[CTL_INIT_BIT];
  endsequence
  AST_SEED: assert property (@(posedge pclk) disable iff (!presetn)
    s_seed_write |=> (s_reg.crc == SEED_ONE || s_reg.crc == SEED_ZERO))
    else $error("seed not loaded");
  AST_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    s_seed_write and (pwdata[CTL_SEL_BIT] && s_reg.st == IDLE) |=> s_reg.crc == SEED_ONE)
    else $error("wrong seed");
  AST_FOLD: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFF_INPUT && s_reg.st == IDLE |=> s_reg.crc == $past(fold_bus))
    else $error("byte not folded");
  AST_PNT: assert property (@(posedge pclk) disable iff (!presetn)
    access && paddr == OFF_RESULT |=> s_reg.pnt != $past(s_reg.pnt))
    else $error("pointer not advanced");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !access && s_reg.st != WAITD |=> $stable(s_reg.crc))
    else $error("result changed");
  AST_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st != IDLE |-> s_reg.stall)
    else $error("no stall in scan");
  AST_START: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFF_CONTROL && s_reg.auto_cfg[AUTO_EN_BIT] && s_reg.count != 8'h00
      && s_reg.st == IDLE |=> s_reg.st == REQ ##1 mem_req)
    else $error("scan not started");
  AST_FLIP: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == OFF_FLIP |=> prdata[0] == s_reg.flip[7] && prdata[7] == s_reg.flip[0])
    else $error("mirror wrong");
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> pready ##1 !pready)
    else $error("ready not one cycle");
endmodule : crc_engine

// ### verilog/crc_pkg.sv
// shared constants and types for the checksum engine
// assumes a 32-bit apb register bus and a byte-wide program memory read port
package crc_pkg;
  localparam logic [15:0] POLY = 16'h1021;
  localparam logic [15:0] SEED_ZERO = 16'h0000;
  localparam logic [15:0] SEED_ONE = 16'hFFFF;
  localparam int BLOCK_BYTES = 256;
  localparam logic [7:0] BLOCK_LAST = 8'hFF;
  // register byte addresses
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_INPUT = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_AUTO = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_FLIP = 8'h14;
  // control register fields
  localparam int CTL_SEL_BIT = 2;
  localparam int CTL_INIT_BIT = 3;
  localparam int CTL_PNT_BIT = 0;
  localparam int CTL_BUSY_BIT = 4;
  // auto config fields
  localparam int AUTO_EN_BIT = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {IDLE, REQ, WAITD} scan_state_type;

  typedef struct packed {
    logic sel;
    logic pnt;
    logic [15:0] crc;
    logic [7:0] auto_cfg;
    logic [7:0] count;
    logic [7:0] flip;
    logic [7:0] offset;
    scan_state_type st;
    logic pready;
    logic [31:0] prdata;
    logic stall;
    logic mem_req;
    logic [15:0] mem_addr;
  } crc_state_type;
endpackage : crc_pkg

// ### verilog/crc_byte_step.sv
// folds one byte into a 16-bit checksum, msb first
// assumes nothing beyond combinational use
`timescale 1ns/1ps
module crc_byte_step
  import crc_pkg::*;
(
  input wire logic [15:0] crc_in, // running value
  input wire logic [7:0] data, // byte to fold
  output logic [15:0] crc_out // folded value
);
  // eight shift steps with polynomial feedback, no reflection
  always_comb
  begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ data[i])
        c = {c[14:0], 1'b0} ^ POLY;
      else
        c = {c[14:0], 1'b0};
    end
    crc_out = c;
  end
endmodule : crc_byte_step

// ### verilog/bit_mirror.sv
// mirrors the bit order of one byte
// assumes nothing beyond combinational use
`timescale 1ns/1ps
module bit_mirror
  import crc_pkg::*;
(
  input wire logic [7:0] din, // byte in
  output logic [7:0] dout // mirrored byte
);
  // one wire per bit
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      assign dout[g] = din[7 - g];
    end
  endgenerate
endmodule : bit_mirror

// ### tb/flash_model.sv
// program memory read port model for the scan
// assumes data is wanted in the same cycle that mem_req and mem_addr stand
`timescale 1ns/1ps
module flash_model
(
  input wire logic clk, // system clock
  input wire logic req, // read strobe
  input wire logic [15:0] addr, // byte address
  output logic [7:0] rdata // read byte
);
  // answer while req stands, show a junk pattern otherwise
  always_comb
  begin
    if (req)
      rdata = addr[7:0] ^ addr[15:8] ^ 8'h5A;
    else
      rdata = 8'hA5;
  end
endmodule : flash_model

// ### tb/crc_engine_tb_top.sv
// self-checking bench for the checksum engine
// assumes an apb slave with wait states and the flash model on the scan port
`timescale 1ns/1ps
module crc_engine_tb_top
  import crc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, cpu_stall, mem_req, err;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  int n_fail = 0;
  int check_count = 0;

  crc_engine i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_stall(cpu_stall), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  flash_model i_mem (.clk(pclk), .req(mem_req), .addr(mem_addr), .rdata(mem_rdata));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // reference fold, msb first
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
    return r;
  endfunction : fold

  // result read, low byte then high byte
  task automatic rres(input logic [15:0] e);
    logic [15:0] v;
    apb(1'b0, OFF_RESULT, 32'h0000_0000);
    v[7:0] = rv[7:0];
    apb(1'b0, OFF_RESULT, 32'h0000_0000);
    v[15:8] = rv[7:0];
    chk({16'h0000, v}, {16'h0000, e});
  endtask : rres

  task automatic t_port;
    logic [15:0] e;
    logic [7:0] fin [3] = '{8'hC0, 8'h01, 8'h1E};
    logic [7:0] fout [3] = '{8'h03, 8'h80, 8'h78};
    rres(16'h0000);
    apb(1'b1, OFF_CONTROL, 32'h0000_000C);
    rres(16'hFFFF);
    e = 16'hFFFF;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, OFF_INPUT, {24'h0000_00, fin[i]});
      e = fold(e, fin[i]);
    end
    rres(e);
    rres(e);
    apb(1'b1, OFF_RESULT, 32'h0000_0034);
    apb(1'b1, OFF_RESULT, 32'h0000_0012);
    rres(16'h1234);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, OFF_FLIP, {24'h0000_00, fin[i]});
      apb(1'b0, OFF_FLIP, 32'h0000_0000);
      chk(rv, {24'h0000_00, fout[i]});
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
  endtask : t_port

  // one block scan from page 1
  task automatic t_scan;
    logic [15:0] e;
    int n;
    apb(1'b1, OFF_CONTROL, 32'h0000_0008);
    apb(1'b1, OFF_AUTO, 32'h0000_0081);
    apb(1'b1, OFF_COUNT, 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0000_0000);
    n = 0;
    @(posedge pclk);
    chk({31'h0000_0000, cpu_stall}, 32'h0000_0001);
    while (cpu_stall === 1'b1 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0000_0000, n >= 500 && n < 1000}, 32'h0000_0001);
    apb(1'b1, OFF_AUTO, 32'h0000_0000);
    e = 16'h0000;
    for (int k = 0; k < 256; k++)
      e = fold(e, 8'(k) ^ 8'h02 ^ 8'h5A);
    rres(e);
  endtask : t_scan

  task automatic conclude;
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_port();
    t_scan();
    conclude();
  end

  // watchdog
  initial
  begin
    #100000;
    n_fail++;
    conclude();
  end
endmodule : crc_engine_tb_top
